/* hw/sfc_core.sv */
// Contract
// - volatile enable arms next status write only
// - write disable clears write enable latch
// - latch cleared at reset and operation completion
// - status read shifts selected byte MSB first
// - status read allowed always, repeats until deselect
// - status write touches only writable bit positions
// - stored lock bits never fall; volatile protects high bit
// - non-volatile status write needs latch set
// - status write needs exactly 8 or 16 bits
// - one-byte write clears complement, quad, protect-high
// - non-volatile write is busy, then clears latch
// - volatile write refreshes shortly, never busy
// - reset instruction restores stored status
// - quad enable frozen in four-line mode
// - all status bits start at zero
// - read takes address, streams incrementing bytes
// - reads ignored while busy
// - plain read only in single-line mode
// - single-line fast read uses eight dummy clocks
// - four-line fast read dummy set 2..8
// - dual read eight dummies, two lines, single mode
// - quad output read needs quad enable bit
// - dual lines carry odd then even bits
// - quad lines carry upper nibble first
// - write enable sets the latch
`timescale 1ns/10ps
module sfc_core import sfc_pkg::*; #(
  parameter int STATUS_WRITE_CYCLES_P = STATUS_WRITE_CYCLES
) (
  input  wire logic       sys_clk_in,
  input  wire logic       arst_n_in,
  input  wire logic       sclk_in,
  input  wire logic       cs_n_in,
  input  wire logic [3:0] io_in,
  output logic      [3:0] io_out,
  output logic      [3:0] io_oe_out,
  input  wire logic       four_line_command_mode_in,
  input  wire logic       read_param_load_in,
  input  wire logic [1:0] read_param_in,
  input  wire logic       ext_op_done_in,
  input  wire logic       array_wr_en_in,
  input  wire logic [7:0] array_wr_addr_in,
  input  wire logic [7:0] array_wr_data_in,
  output logic            busy_out,
  output logic            write_enable_latch_out,
  output logic      [15:0] status_out
);

  // ****************************************
  // pin sampling and edge detection
  // ****************************************
  sfc_pins_t  pins;
  logic       sclk_q;
  logic       cs_q;
  wire        sclk_rise = pins.sclk & ~sclk_q;
  wire        sclk_fall = ~pins.sclk & sclk_q;
  wire        cs_rise   = pins.cs_n & ~cs_q;
  wire        selected  = ~pins.cs_n;
  wire        four_line_command_mode       = four_line_command_mode_in;

  sfc_pin_sync u_sync (
    .sys_clk_in (sys_clk_in),
    .arst_n_in  (arst_n_in),
    .pins_in    ({cs_n_in, sclk_in, io_in}),
    .pins_out   (pins)
  );

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
    end else begin
      sclk_q <= pins.sclk;
      cs_q   <= pins.cs_n;
    end
  end

  // ****************************************
  // state and shifter
  // ****************************************
  sfc_state_t state;
  sfc_lanes_t out_lanes;
  logic [7:0]  opcode;
  logic [23:0] shreg;
  logic [23:0] addr;
  logic [5:0]  cnt;
  logic [3:0]  dummy_left;
  logic [7:0]  tx_byte;
  logic [2:0]  tx_pos;
  logic        sr2_sel;

  logic [15:0] act_sr;
  logic [15:0] nv_sr;
  logic [15:0] pend_sr;
  logic        write_enable_latch;
  logic        busy;
  logic        vol_arm;
  logic        vol_pend;
  logic        rst_arm;
  logic [1:0]  dummy_sel;
  logic [18:0] tmr;
  logic [7:0]  mem_rdata;

  wire sfc_lanes_t in_lanes = four_line_command_mode ? LN_FOUR : LN_ONE;
  wire [5:0]  next_cnt   = cnt + lane_bits(in_lanes);
  wire [23:0] next_shreg = four_line_command_mode ? {shreg[19:0], pins.io} : {shreg[22:0], pins.io[0]};
  wire [7:0]  cmd_now    = next_shreg[7:0];

  // ****************************************
  // instruction decode
  // ****************************************
  wire is_rd     = cmd_now == OP_READ && !four_line_command_mode;
  wire is_fast   = cmd_now == OP_FREAD;
  wire is_dual   = cmd_now == OP_DREAD && !four_line_command_mode;
  wire is_quad   = cmd_now == OP_QREAD && !four_line_command_mode && act_sr[SR_QE_BIT];
  wire any_read  = (is_rd || is_fast || is_dual || is_quad) && !busy;
  wire is_srd    = cmd_now == OP_RDSR1 || cmd_now == OP_RDSR2;
  wire is_simple = (cmd_now == OP_WREN || cmd_now == OP_WRDI || cmd_now == OP_VWREN ||
                    cmd_now == OP_RSTEN || cmd_now == OP_RST) && !busy;
  wire is_wsr    = cmd_now == OP_WRSR && !busy;
  wire [3:0] qpi_dummy = {1'b0, dummy_sel, 1'b0} + 4'h2;
  wire [3:0] dummy_clks = (opcode == OP_FREAD && four_line_command_mode) ? qpi_dummy : SPI_DUMMY_CLKS;
  wire sfc_lanes_t rd_lanes = (cmd_now == OP_QREAD || four_line_command_mode) ? LN_FOUR :
                              (cmd_now == OP_DREAD) ? LN_TWO : LN_ONE;
  wire sfc_lanes_t op_lanes = (opcode == OP_QREAD || four_line_command_mode) ? LN_FOUR :
                              (opcode == OP_DREAD) ? LN_TWO : LN_ONE;

  // ****************************************
  // status write merge
  // ****************************************
  wire        wsr_two  = cnt == WSR_TWO_BYTES;
  wire        wsr_ok   = state == ST_WSR && (wsr_two || cnt == WSR_ONE_BYTE);
  wire        wsr_vol  = vol_arm;
  wire        wsr_go   = wsr_ok && (wsr_vol || write_enable_latch);
  wire [15:0] wsr_base = wsr_vol ? act_sr : nv_sr;
  wire [15:0] wsr_raw  = wsr_two ? {shreg[7:0], shreg[15:8]} :
                         {wsr_base[15:8], shreg[7:0]} & ~SR_ONE_BYTE_CLR;
  wire [15:0] wsr_keep = (wsr_base & SR_LB_MASK) | (wsr_vol ? (wsr_base & SR_STATUS_PROTECT_HI_MASK) : 16'h0000);
  wire [15:0] wsr_qe   = four_line_command_mode ? SR_QE_MASK : 16'h0000;
  wire [15:0] wsr_mix  = (wsr_base & ~SR_WR_MASK) | (wsr_raw & SR_WR_MASK) | wsr_keep;
  wire [15:0] wsr_new  = (wsr_mix & ~wsr_qe) | (wsr_base & wsr_qe);

  wire tail_done  = state == ST_TAIL && cs_rise && cnt == CMD_BITS;
  wire do_wren    = tail_done && opcode == OP_WREN;
  wire do_wrdi    = tail_done && opcode == OP_WRDI;
  wire do_vwren   = tail_done && opcode == OP_VWREN;
  wire do_rsten   = tail_done && opcode == OP_RSTEN;
  wire do_rst     = tail_done && opcode == OP_RST && rst_arm;
  wire nv_start   = cs_rise && wsr_go && !wsr_vol;
  wire vol_start  = cs_rise && wsr_go && wsr_vol;
  wire tmr_done   = tmr == 19'h00000;
  wire nv_done    = busy && tmr_done;
  wire vol_done   = vol_pend && tmr_done;
  wire instr_end  = cs_rise && state != ST_IDLE && state != ST_SRD;

  // ****************************************
  // output slice
  // ****************************************
  wire [7:0] status1  = {act_sr[7:2], write_enable_latch, busy};
  wire [7:0] status2  = act_sr[15:8];
  wire [7:0] tx_src   = (state == ST_SRD) ? (sr2_sel ? status2 : status1) : mem_rdata;
  wire [7:0] tx_cur   = (tx_pos == 3'h0) ? tx_src : tx_byte;
  wire       tx_state = state == ST_DATA || state == ST_SRD;
  wire [5:0] tx_lanes = lane_bits(out_lanes);
  wire [2:0] tx_step  = tx_lanes[2:0];

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state      <= ST_IDLE;
      opcode     <= 8'h00;
      shreg      <= 24'h000000;
      addr       <= 24'h000000;
      cnt        <= 6'h00;
      dummy_left <= 4'h0;
      out_lanes  <= LN_ONE;
      sr2_sel    <= 1'b0;
    end else if (!selected) begin
      state <= ST_IDLE;
    end else if (state == ST_IDLE) begin
      state <= ST_CMD;
      cnt   <= 6'h00;
    end else if (sclk_rise) begin
      shreg <= next_shreg;
      cnt   <= (next_cnt > 6'h30) ? 6'h30 : next_cnt;
      case (state)
        ST_CMD: begin
          if (next_cnt == CMD_BITS) begin
            opcode  <= cmd_now;
            cnt     <= 6'h00;
            sr2_sel <= cmd_now == OP_RDSR2;
            if (is_srd) begin
              state     <= ST_SRD;
              out_lanes <= in_lanes;
            end else if (any_read) begin
              state     <= ST_ADDR;
              out_lanes <= rd_lanes;
            end else if (is_wsr) begin
              state <= ST_WSR;
            end else if (is_simple) begin
              state <= ST_TAIL;
              cnt   <= CMD_BITS;
            end else begin
              state <= ST_TAIL;
            end
          end
        end
        ST_ADDR: begin
          if (next_cnt == ADDR_BITS) begin
            addr       <= next_shreg;
            dummy_left <= dummy_clks;
            state      <= (opcode == OP_READ) ? ST_DATA : ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          dummy_left <= dummy_left - 4'h1;
          if (dummy_left == 4'h1) begin
            state <= ST_DATA;
          end
        end
        ST_DATA: begin
        end
        default: begin
        end
      endcase
    end else if (sclk_fall && tx_state && tx_pos == 3'h0 && state == ST_DATA) begin
      addr <= addr + 24'h000001;
    end
  end

  // ****************************************
  // output shifter, driven on falling edges
  // ****************************************
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      io_out    <= 4'h0;
      io_oe_out <= 4'h0;
      tx_byte   <= 8'h00;
      tx_pos    <= 3'h0;
    end else if (!tx_state || !selected) begin
      io_oe_out <= 4'h0;
      tx_pos    <= 3'h0;
    end else if (sclk_fall) begin
      io_out    <= lane_slice(tx_cur, tx_pos, out_lanes);
      io_oe_out <= lane_oe(out_lanes);
      tx_byte   <= tx_cur;
      tx_pos    <= tx_pos + tx_step;
    end
  end

  // ****************************************
  // status, latch and timed cycles
  // ****************************************
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      act_sr    <= SR_FACTORY;
      nv_sr     <= SR_FACTORY;
      pend_sr   <= SR_FACTORY;
      write_enable_latch       <= 1'b0;
      busy      <= 1'b0;
      vol_arm   <= 1'b0;
      vol_pend  <= 1'b0;
      rst_arm   <= 1'b0;
      dummy_sel <= DUMMY_SEL_RST;
      tmr       <= 19'h00000;
    end else begin
      if (!tmr_done) begin
        tmr <= tmr - 19'h00001;
      end
      if (instr_end) begin
        vol_arm <= do_vwren;
        rst_arm <= do_rsten;
      end
      if (read_param_load_in) begin
        dummy_sel <= read_param_in;
      end
      if (nv_start) begin
        pend_sr <= wsr_new;
        busy    <= 1'b1;
        tmr     <= 19'(STATUS_WRITE_CYCLES_P - 1);
      end else if (vol_start) begin
        pend_sr  <= wsr_new;
        vol_pend <= 1'b1;
        tmr      <= 19'(VOLATILE_REFRESH_CYCLES - 1);
      end else if (nv_done) begin
        busy   <= 1'b0;
        nv_sr  <= pend_sr;
        act_sr <= pend_sr;
      end else if (vol_done) begin
        vol_pend <= 1'b0;
        act_sr   <= pend_sr;
      end else if (do_rst) begin
        act_sr    <= nv_sr;
        dummy_sel <= DUMMY_SEL_RST;
      end
      if (do_wren) begin
        write_enable_latch <= 1'b1;
      end else if (do_wrdi || nv_done || do_rst || ext_op_done_in) begin
        write_enable_latch <= 1'b0;
      end
    end
  end

  sfc_array_mem u_mem (
    .sys_clk_in  (sys_clk_in),
    .arst_n_in   (arst_n_in),
    .wr_en_in    (array_wr_en_in),
    .wr_addr_in  (array_wr_addr_in),
    .wr_data_in  (array_wr_data_in),
    .rd_addr_in  (addr[7:0]),
    .rd_data_out (mem_rdata)
  );

  assign busy_out               = busy;
  assign write_enable_latch_out = write_enable_latch;
  assign status_out             = {status2, status1};

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  sequence nv_write_begins;
    nv_start ##1 busy;
  endsequence

  sequence nv_write_ends;
    $fell(busy) ##0 !write_enable_latch;
  endsequence

  wrdi_clears_latch_a: assert property (do_wrdi && !do_wren |=> !write_enable_latch)
    else $error("write disable left latch set");
  wren_sets_latch_a: assert property (do_wren |=> write_enable_latch)
    else $error("write enable did not set latch");
  nv_busy_start_a: assert property (nv_start |-> nv_write_begins)
    else $error("non-volatile status write not busy");
  nv_busy_end_a: assert property ($fell(busy) |-> nv_write_ends)
    else $error("latch still set after status write cycle");
  vol_not_busy_a: assert property (vol_start |=> !busy [*2] ##0 vol_pend)
    else $error("volatile write raised busy");
  vol_refresh_a: assert property (vol_start |-> ##[1:4] !vol_pend)
    else $error("volatile refresh too slow");
  lock_bits_keep_a: assert property (!$past(do_rst) |-> (($past(act_sr) & ~act_sr & SR_LB_MASK) == 16'h0000))
    else $error("lock bit fell");
  ro_bits_zero_a: assert property ((act_sr & ~SR_WR_MASK) == 16'h0000)
    else $error("read-only status bit set");
  qpi_no_read_a: assert property (state == ST_CMD && sclk_rise && four_line_command_mode && cmd_now == OP_READ &&
                                  next_cnt == CMD_BITS |=> state != ST_ADDR)
    else $error("plain read accepted in four-line mode");
  busy_read_ign_a: assert property ($rose(state == ST_ADDR) |-> !busy)
    else $error("read started while busy");
  short_abort_a: assert property (cs_rise && state == ST_CMD |=> $stable(write_enable_latch) && $stable(act_sr))
    else $error("short instruction changed state");
  oe_frame_a: assert property (io_oe_out != 4'h0 |-> $past(selected) && $past(tx_state))
    else $error("io driven outside a data phase");

endmodule : sfc_core

/* hw/sfc_pkg.sv */
package sfc_pkg;

  // ****************************************
  // instruction codes
  // ****************************************
  localparam logic [7:0] OP_WREN  = 8'h06;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_VWREN = 8'h50;
  localparam logic [7:0] OP_RDSR1 = 8'h05;
  localparam logic [7:0] OP_RDSR2 = 8'h35;
  localparam logic [7:0] OP_WRSR  = 8'h01;
  localparam logic [7:0] OP_READ  = 8'h03;
  localparam logic [7:0] OP_FREAD = 8'h0B;
  localparam logic [7:0] OP_DREAD = 8'h3B;
  localparam logic [7:0] OP_QREAD = 8'h6B;
  localparam logic [7:0] OP_RSTEN = 8'h66;
  localparam logic [7:0] OP_RST   = 8'h99;

  // ****************************************
  // status layout and reset values
  // ****************************************
  localparam logic [15:0] SR_WR_MASK   = 16'h7FFC;
  localparam logic [15:0] SR_LB_MASK   = 16'h3C00;
  localparam logic [15:0] SR_STATUS_PROTECT_HI_MASK = 16'h0100;
  localparam logic [15:0] SR_QE_MASK   = 16'h0200;
  localparam logic [15:0] SR_ONE_BYTE_CLR = 16'h4300;
  localparam logic [15:0] SR_FACTORY   = 16'h0000;
  localparam int          SR_QE_BIT    = 9;

  // ****************************************
  // sequence lengths
  // ****************************************
  localparam logic [5:0] CMD_BITS       = 6'h08;
  localparam logic [5:0] ADDR_BITS      = 6'h18;
  localparam logic [5:0] WSR_ONE_BYTE   = 6'h08;
  localparam logic [5:0] WSR_TWO_BYTES  = 6'h10;
  localparam logic [3:0] SPI_DUMMY_CLKS = 4'h8;
  localparam logic [1:0] DUMMY_SEL_RST  = 2'h0;
  localparam logic [7:0] SYNC_RESET     = 8'h20;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS             = 25;
  localparam int STATUS_WRITE_CYCLE_TIME_US = 10;
  localparam int STATUS_WRITE_CYCLES       = STATUS_WRITE_CYCLE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int VOLATILE_REFRESH_TIME_NS  = 50;
  localparam int VOLATILE_REFRESH_CYCLES   =
    (VOLATILE_REFRESH_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : VOLATILE_REFRESH_TIME_NS / CLK_PERIOD_NS;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic       cs_n;
    logic       sclk;
    logic [3:0] io;
  } sfc_pins_t;

  typedef enum logic [1:0] {LN_ONE, LN_TWO, LN_FOUR} sfc_lanes_t;

  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_SRD, ST_WSR, ST_TAIL} sfc_state_t;

  function automatic logic [5:0] lane_bits(input sfc_lanes_t ln);
    lane_bits = (ln == LN_FOUR) ? 6'h04 : (ln == LN_TWO) ? 6'h02 : 6'h01;
  endfunction : lane_bits

  function automatic logic [3:0] lane_oe(input sfc_lanes_t ln);
    lane_oe = (ln == LN_FOUR) ? 4'hF : (ln == LN_TWO) ? 4'h3 : 4'h2;
  endfunction : lane_oe

  // single data leaves on io1; dual puts odd bits on io1
  function automatic logic [3:0] lane_slice(input logic [7:0] b, input logic [2:0] pos, input sfc_lanes_t ln);
    logic [2:0] hi;
    hi = 3'h7 - pos;
    if (ln == LN_FOUR) begin
      lane_slice = pos[2] ? b[3:0] : b[7:4];
    end else if (ln == LN_TWO) begin
      lane_slice = {2'h0, b[hi], b[hi - 3'h1]};
    end else begin
      lane_slice = {2'h0, b[hi], 1'b0};
    end
  endfunction : lane_slice

endpackage : sfc_pkg

/* hw/sfc_pin_sync.sv */
`timescale 1ns/10ps
module sfc_pin_sync import sfc_pkg::*; (
  input  wire logic      sys_clk_in,
  input  wire logic      arst_n_in,
  input  wire sfc_pins_t pins_in,
  output sfc_pins_t      pins_out
);

  sfc_pins_t meta;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta     <= SYNC_RESET[5:0];
      pins_out <= SYNC_RESET[5:0];
    end else begin
      meta     <= pins_in;
      pins_out <= meta;
    end
  end

endmodule : sfc_pin_sync

/* hw/sfc_array_mem.sv */
`timescale 1ns/10ps
module sfc_array_mem (
  input  wire logic       sys_clk_in,
  input  wire logic       arst_n_in,
  input  wire logic       wr_en_in,
  input  wire logic [7:0] wr_addr_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic [7:0] rd_addr_in,
  output logic      [7:0] rd_data_out
);

  logic [7:0] mem [256];

  always_ff @(posedge sys_clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_data_out <= 8'h00;
    end else begin
      rd_data_out <= mem[rd_addr_in];
    end
  end

endmodule : sfc_array_mem

/* dv/sfc_host_model.sv */
`timescale 1ns/10ps
// ****************************************
// host side of the link, clock idles low
// ****************************************
module sfc_host_model import sfc_pkg::*; (
  output logic            cs_n_out,
  output logic            sclk_out,
  output logic      [3:0] io_out,
  input  wire logic [3:0] io_dev_in,
  input  wire logic [3:0] io_oe_in
);
  logic [3:0] hoe;
  logic [3:0] hv;
  logic [3:0] smp;
  logic       flip;
  logic       quad_tx;

  initial begin
    quad_tx = 1'b0;
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    hoe = 4'h0;
    hv = 4'h0;
    smp = 4'h0;
    flip = 1'b0;
  end

  // undriven lines keep changing so a stale value never reads as data
  always #50 flip = ~flip;
  assign io_out = (io_oe_in & io_dev_in) | (~io_oe_in & ((hoe & hv) | (~hoe & {4{flip}})));

  // one 200 ns clock; data set while low, sampled late in the high phase
  task automatic tick();
    #100 sclk_out = 1'b1;
    #95 smp = io_out;
    #5 sclk_out = 1'b0;
  endtask : tick

  task automatic frame(input logic [31:0] tx, input int ntx, input int ndum, input int lanes, input int nrx,
                       output logic [63:0] rx);
    int i;
    rx = 64'h0;
    cs_n_out = 1'b0;
    #100;
    for (i = 0; i < ntx; i += (quad_tx ? 4 : 1)) begin
      hoe = quad_tx ? 4'hF : 4'h1;
      hv = quad_tx ? tx[(ntx - 1 - i) -: 4] : {3'h0, tx[ntx - 1 - i]};
      tick();
    end
    hoe = 4'h0;
    for (i = 0; i < ndum; i++) begin
      tick();
    end
    for (i = 0; i < nrx; i++) begin
      tick();
      rx = (rx << lanes) | ((lanes == 1) ? {63'h0, smp[1]} : {60'h0, smp & ((lanes == 2) ? 4'h3 : 4'hF)});
    end
    #100 cs_n_out = 1'b1;
    #300;
  endtask : frame
endmodule : sfc_host_model

/* dv/testbench.sv */
`timescale 1ns/10ps
module testbench import sfc_pkg::*; ();
  localparam int WCYC = 2000;
  logic        sys_clk;
  logic        arst_n;
  logic        ext_done;
  logic        a_en;
  logic [7:0]  a_addr;
  logic [3:0]  io_w;
  logic [3:0]  io_d;
  logic [3:0]  io_oe;
  logic        cs_n;
  logic        sclk;
  logic        busy;
  logic        write_enable_latch;
  logic [15:0] status;
  logic [63:0] rx;
  logic        oe_seen;
  logic        four_line_command_mode;
  logic        rp_load;
  logic [1:0]  rp;
  int          bad_count;
  int          n_tests;
  int          busy_cnt;
  int          i;

  sfc_core #(.STATUS_WRITE_CYCLES_P(WCYC)) dut (.sys_clk_in(sys_clk), .arst_n_in(arst_n), .sclk_in(sclk),
    .cs_n_in(cs_n), .io_in(io_w), .io_out(io_d), .io_oe_out(io_oe), .four_line_command_mode_in(four_line_command_mode),
    .read_param_load_in(rp_load), .read_param_in(rp), .ext_op_done_in(ext_done), .array_wr_en_in(a_en),
    .array_wr_addr_in(a_addr), .array_wr_data_in(a_addr ^ 8'h5A), .busy_out(busy),
    .write_enable_latch_out(write_enable_latch), .status_out(status));
  sfc_host_model host (.cs_n_out(cs_n), .sclk_out(sclk), .io_out(io_w), .io_dev_in(io_d), .io_oe_in(io_oe));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (|io_oe) oe_seen <= 1'b1;
    if (busy === 1'b1) busy_cnt <= busy_cnt + 1;
  end

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic run(input logic [31:0] tx, input int ntx, input int ndum, input int lanes, input int nrx);
    @(negedge sys_clk);
    oe_seen = 1'b0;
    host.frame(tx, ntx, ndum, lanes, nrx, rx);
    repeat (4) @(negedge sys_clk);
  endtask : run

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    #400000;
    bad_count++;
    end_sim();
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    arst_n = 1'b0;
    ext_done = 1'b0;
    four_line_command_mode = 1'b0;
    rp_load = 1'b0;
    rp = 2'h0;
    a_en = 1'b0;
    a_addr = 8'h00;
    oe_seen = 1'b0;
    busy_cnt = 0;
    bad_count = 0;
    n_tests = 0;
    repeat (5) @(negedge sys_clk);
    arst_n = 1'b1;
    chk("status after reset", 16'h0000, status);
    for (i = 0; i < 32; i++) begin
      a_en = 1'b1;
      a_addr = i[7:0];
      @(negedge sys_clk);
    end
    a_en = 1'b0;
    $display("test reset done");
    run(32'h06, 8, 0, 1, 0);
    chk("latch set", 1'b1, write_enable_latch);
    ext_done = 1'b1;
    @(negedge sys_clk);
    ext_done = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("latch after op done", 1'b0, write_enable_latch);
    run(32'h06, 8, 0, 1, 0);
    run(32'h0, 4, 0, 1, 0);
    chk("latch after short code", 1'b1, write_enable_latch);
    run(32'h04, 8, 0, 1, 0);
    chk("latch after disable", 1'b0, write_enable_latch);
    $display("test latch done");
    run(32'h01FFFF, 24, 0, 1, 0);
    chk("status write without latch", 16'h0000, status);
    run(32'h06, 8, 0, 1, 0);
    busy_cnt = 0;
    run(32'h01FFFF, 24, 0, 1, 0);
    chk("busy after stored write", 1'b1, busy);
    run(32'h03000010, 32, 0, 1, 8);
    chk("read drive while busy", 1'b0, oe_seen);
    run(32'h05, 8, 0, 1, 16);
    chk("status1 while busy", 16'h0303, rx);
    for (i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge sys_clk);
    chk("busy length", WCYC, busy_cnt);
    chk("status after stored write", 16'h7FFC, status);
    chk("latch after stored write", 1'b0, write_enable_latch);
    run(32'h05, 8, 0, 1, 16);
    chk("status1 stream", 16'hFCFC, rx);
    run(32'h35, 8, 0, 1, 16);
    chk("status2 stream", 16'h7F7F, rx);
    $display("test stored status write done");
    run(32'h03000010, 32, 0, 1, 16);
    chk("plain read", {8'h10 ^ 8'h5A, 8'h11 ^ 8'h5A}, rx);
    run(32'h0B000012, 32, 8, 1, 16);
    chk("fast read", {8'h12 ^ 8'h5A, 8'h13 ^ 8'h5A}, rx);
    run(32'h3B000014, 32, 8, 2, 8);
    chk("dual read", {8'h14 ^ 8'h5A, 8'h15 ^ 8'h5A}, rx);
    run(32'h6B00001E, 32, 8, 4, 4);
    chk("quad read", {8'h1E ^ 8'h5A, 8'h1F ^ 8'h5A}, rx);
    $display("test reads done");
    run(32'h50, 8, 0, 1, 0);
    busy_cnt = 0;
    run(32'h0100, 16, 0, 1, 0);
    chk("volatile one byte write", 16'h3D00, status);
    chk("volatile write busy", 0, busy_cnt);
    run(32'h50, 8, 0, 1, 0);
    run(32'h01FFF, 20, 0, 1, 0);
    chk("twelve bit write", 16'h3D00, status);
    run(32'h6B00001E, 32, 8, 4, 4);
    chk("quad read refused", 1'b0, oe_seen);
    run(32'h66, 8, 0, 1, 0);
    run(32'h99, 8, 0, 1, 0);
    chk("status after reset instruction", 16'h7FFC, status);
    $display("test volatile status done");
    four_line_command_mode = 1'b1;
    host.quad_tx = 1'b1;
    run(32'h50, 8, 0, 1, 0);
    run(32'h010000, 24, 0, 1, 0);
    chk("four-line volatile write", 16'h3F00, status);
    run(32'h03000010, 32, 0, 4, 4);
    chk("four-line plain read refused", 1'b0, oe_seen);
    run(32'h0B000010, 32, 2, 4, 4);
    chk("four-line fast read default", {8'h10 ^ 8'h5A, 8'h11 ^ 8'h5A}, rx);
    rp = 2'h1;
    rp_load = 1'b1;
    @(negedge sys_clk);
    rp_load = 1'b0;
    run(32'h0B000012, 32, 4, 4, 4);
    chk("four-line fast read four dummies", {8'h12 ^ 8'h5A, 8'h13 ^ 8'h5A}, rx);
    $display("test four-line done");
    end_sim();
  end
endmodule : testbench
